// [bfmc_pkg.sv]
// constants and types for the two-way fifo reset, offset and mailbox control block
// assumes a single 40 MHz clock shared by both ports and all control pins
package bfmc_pkg;

  // datapath shape
  localparam int DATA_W    = 36;
  localparam int DEPTH     = 16;
  localparam int PTR_W     = 4;
  localparam int LVL_W     = 5;
  localparam int OFS_W     = 7;

  localparam logic [LVL_W-1:0] FULL_LEVEL = 5'h10;

  // reset qualification: low edges needed before a fifo reset takes effect
  localparam int               RST_CNT_W = 3;
  localparam logic [RST_CNT_W-1:0] RST_EDGES = 3'h4;
  localparam logic [RST_CNT_W-1:0] RST_ONE   = 3'h1;

  // reset pins in the qualifier array
  localparam int RST_PINS   = 4;
  localparam int RST_MST1   = 0;
  localparam int RST_PRT1   = 1;
  localparam int RST_MST2   = 2;
  localparam int RST_PRT2   = 3;

  // flag-select codes caught at master reset release
  localparam logic [1:0] FS_PRESET_8  = 2'h0;
  localparam logic [1:0] FS_PRESET_16 = 2'h1;
  localparam logic [1:0] FS_PRESET_64 = 2'h2;
  localparam logic [1:0] FS_PROGRAM   = 2'h3;

  localparam logic [OFS_W-1:0] PRESET_8  = 7'h08;
  localparam logic [OFS_W-1:0] PRESET_16 = 7'h10;
  localparam logic [OFS_W-1:0] PRESET_64 = 7'h40;

  // offset programming order: fifo one full, fifo one empty, fifo two full, fifo two empty
  localparam logic [1:0] IDX_Y1 = 2'h0;
  localparam logic [1:0] IDX_X1 = 2'h1;
  localparam logic [1:0] IDX_Y2 = 2'h2;
  localparam logic [1:0] IDX_X2 = 2'h3;

  localparam int               SER_BITS  = 4 * OFS_W;
  localparam int               SER_CNT_W = 5;
  localparam logic [SER_CNT_W-1:0] SER_LAST = 5'h1B;
  localparam logic [SER_CNT_W-1:0] SER_ONE  = 5'h01;

  typedef enum logic [1:0] {PROG_IDLE, PROG_PAR, PROG_SER} bfmc_prog_t;

endpackage

// [bfmc_rstq.sv]
// reset qualifier: counts clock edges seen while a fifo reset pin is low
// assumes the pin is synchronous to clk
`timescale 1ns/100ps
module bfmc_rstq
  import bfmc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // reset pin
  input  wire logic pin_n,
  // qualified reset level and release pulse
  output logic      hit,
  output logic      release_pulse
);

  logic [RST_CNT_W-1:0] cnt_q;
  logic [RST_CNT_W-1:0] cnt_d;

  // saturate so a long reset does not wrap
  assign cnt_d = pin_n ? '0 : (cnt_q == RST_EDGES) ? cnt_q : cnt_q + RST_ONE;
  assign hit           = (cnt_q >= RST_EDGES - RST_ONE) && !pin_n;
  assign release_pulse = (cnt_q == RST_EDGES) && pin_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// [bfmc_fifo.sv]
// memory-backed fifo with registered read data and flush
// assumes flush, push and pop are all on clk
`timescale 1ns/100ps
module bfmc_fifo
  import bfmc_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH_P = DEPTH,
  parameter int AW = PTR_W
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // fill level
  output logic [AW:0]           level
);

  logic [WIDTH-1:0] mem_q [DEPTH_P];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  logic [WIDTH-1:0] out_q;
  logic             push;
  logic             pop;

  assign level     = wp_q - rp_q;
  assign in_ready  = (level != (AW+1)'(DEPTH_P)) && !flush;
  assign out_valid = (level != '0) && !flush;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = out_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      out_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
      if (pop) begin
        out_q <= mem_q[rp_q[AW-1:0]];
      end
    end
  end

endmodule

// [bfmc_ctl.sv]
// two-way fifo control: reset qualification, flag forcing, offset loading, mailboxes
// assumes both ports and every control pin are synchronous to clk
`timescale 1ns/100ps
// Functional notes
// [RL1] fifo one reset low forces its five flags to reset states
// [RL2] fifo two reset low forces its five flags to reset states
// [RL3] mail writes drive mailbox flag low, opposite-port mail reads drive it high
// [RL4] mail one write shows on port b bus when selected and enabled
// [RL5] mail two write shows on port a bus when selected and enabled
// [RL6] mailbox select switches output bus between mail and fifo without a clock
// [RL7] port b bus driven only with chip select low and read selected
// [RL8] fifo reset acts only after four clock edges with reset held low
// [RL9] partial reset pin stays high during master reset of that fifo
// [RL10] master reset pin stays high during partial reset of that fifo
// [RL11] fifo one master reset loads its offsets from the selected preset
// [RL12] fifo two master reset loads its own offsets the same way
// [RL13] fifo two partial reset flushes pointers and forces flags like fifo one
// [RL14] parallel offsets written on port a with mailbox select low, gaps allowed
// [RL15] serial offsets shift in order y1, x1, y2, x2, gaps allowed
// [RL16] port a fifo writes ignored until input ready is high
// [RL17] input ready and empty flags update in the cycle after the causing edge
// [RL18] port a bus driven only with chip select low and read selected
// [RL19] port b empty flag goes low with the final word read
module bfmc_ctl
  import bfmc_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // fifo resets
  input  wire logic              fifo_one_master_reset_n,
  input  wire logic              fifo_one_partial_reset_n,
  input  wire logic              fifo_two_master_reset_n,
  input  wire logic              fifo_two_partial_reset_n,
  // offset configuration
  input  wire logic [1:0]        flag_select,
  input  wire logic              serial_program_select,
  input  wire logic              serial_offset_data,
  input  wire logic              serial_enable_n,
  // port a
  input  wire logic              port_a_chip_select_n,
  input  wire logic              port_a_write_read,
  input  wire logic              port_a_enable,
  input  wire logic              port_a_mailbox_select,
  input  wire logic [DATA_W-1:0] port_a_data_in,
  output logic [DATA_W-1:0]      port_a_data_out,
  output logic                   port_a_data_oe,
  // port b
  input  wire logic              port_b_chip_select_n,
  input  wire logic              port_b_write_read,
  input  wire logic              port_b_enable,
  input  wire logic              port_b_mailbox_select,
  input  wire logic [DATA_W-1:0] port_b_data_in,
  output logic [DATA_W-1:0]      port_b_data_out,
  output logic                   port_b_data_oe,
  // flags
  output logic                   port_a_full_or_input_ready,
  output logic                   port_b_full_or_input_ready,
  output logic                   port_a_empty_or_output_ready,
  output logic                   port_b_empty_or_output_ready,
  output logic                   port_a_almost_empty_n,
  output logic                   port_b_almost_empty_n,
  output logic                   port_a_almost_full_n,
  output logic                   port_b_almost_full_n,
  output logic                   mailbox_one_flag_n,
  output logic                   mailbox_two_flag_n,
  output logic                   offsets_ready
);

  logic [RST_PINS-1:0] rst_pin_n;
  logic [RST_PINS-1:0] rst_hit;
  logic [RST_PINS-1:0] rst_rel;

  logic              rst1_low, rst2_low, flush1, flush2, mst1_rel, mst2_rel;
  logic              a_sel, a_wr, a_rd, b_sel, b_wr, b_rd;
  logic              fifo1_wr_req, fifo2_wr_req, fifo1_push, fifo2_push, fifo1_pop, fifo2_pop;
  logic              mail1_wr, mail2_wr, mail1_rd, mail2_rd, prog_par_wr, ser_shift;
  logic              in_rdy1, in_rdy2, out_vld1, out_vld2, ira, irb;
  logic [DATA_W-1:0] fifo1_dout, fifo2_dout;
  logic [LVL_W-1:0]  lvl1, lvl2, room1, room2;
  logic [OFS_W-1:0]  preset_val;
  logic [SER_BITS-1:0] ser_word;

  logic [DATA_W-1:0] mail1_q, mail2_q;
  logic              mailbox_one_flag_n_q, mailbox_one_flag_n_d, mailbox_two_flag_n_q, mailbox_two_flag_n_d;
  logic [OFS_W-1:0]  x1_q, y1_q, x2_q, y2_q;
  bfmc_prog_t        prog_q;
  logic              prog_done_q;
  logic [1:0]        par_idx_q;
  logic [SER_CNT_W-1:0] ser_cnt_q;
  logic [SER_BITS-1:0]  ser_sr_q;

  // each reset pin gets its own edge counter
  assign rst_pin_n = {fifo_two_partial_reset_n, fifo_two_master_reset_n,
                      fifo_one_partial_reset_n, fifo_one_master_reset_n};

  for (genvar gi = 0; gi < RST_PINS; gi++) begin : g_rstq
    bfmc_rstq u_rstq (
      .clk           (clk),
      .resetn        (resetn),
      .pin_n         (rst_pin_n[gi]),
      .hit           (rst_hit[gi]),
      .release_pulse (rst_rel[gi])
    );
  end

  assign rst1_low = !fifo_one_master_reset_n || !fifo_one_partial_reset_n;
  assign rst2_low = !fifo_two_master_reset_n || !fifo_two_partial_reset_n;
  assign flush1   = rst_hit[RST_MST1] || rst_hit[RST_PRT1]; // RL8
  assign flush2   = rst_hit[RST_MST2] || rst_hit[RST_PRT2]; // RL8 RL13
  assign mst1_rel = rst_rel[RST_MST1]; // RL11
  assign mst2_rel = rst_rel[RST_MST2]; // RL12

  // port decode; port a writes with the select high, port b with it low
  assign a_sel        = !port_a_chip_select_n && port_a_enable;
  assign a_wr         = a_sel && port_a_write_read;
  assign a_rd         = a_sel && !port_a_write_read;
  assign b_sel        = !port_b_chip_select_n && port_b_enable;
  assign b_wr         = b_sel && !port_b_write_read;
  assign b_rd         = b_sel && port_b_write_read;
  assign fifo1_wr_req = a_wr && !port_a_mailbox_select;
  assign fifo2_wr_req = b_wr && !port_b_mailbox_select;
  assign mail1_wr     = a_wr && port_a_mailbox_select;
  assign mail2_wr     = b_wr && port_b_mailbox_select;
  assign mail1_rd     = b_rd && port_b_mailbox_select;
  assign mail2_rd     = a_rd && port_a_mailbox_select;
  assign prog_par_wr  = fifo1_wr_req && (prog_q == PROG_PAR); // RL14
  assign ser_shift    = (prog_q == PROG_SER) && !serial_enable_n; // RL15

  // input ready also stalls port a until offsets are loaded
  assign ira        = in_rdy1 && prog_done_q && !rst1_low; // RL16
  assign irb        = in_rdy2 && !rst2_low;
  assign fifo1_push = fifo1_wr_req && ira; // RL16
  assign fifo2_push = fifo2_wr_req && irb;
  assign fifo1_pop  = b_rd && !port_b_mailbox_select && out_vld1 && !rst1_low;
  assign fifo2_pop  = a_rd && !port_a_mailbox_select && out_vld2 && !rst2_low;

  bfmc_fifo u_fifo1 (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (flush1),
    .in_valid  (fifo1_wr_req && prog_done_q && !rst1_low),
    .in_ready  (in_rdy1),
    .in_data   (port_a_data_in),
    .out_valid (out_vld1),
    .out_ready (fifo1_pop),
    .out_data  (fifo1_dout),
    .level     (lvl1)
  );

  bfmc_fifo u_fifo2 (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (flush2),
    .in_valid  (fifo2_wr_req && !rst2_low),
    .in_ready  (in_rdy2),
    .in_data   (port_b_data_in),
    .out_valid (out_vld2),
    .out_ready (fifo2_pop),
    .out_data  (fifo2_dout),
    .level     (lvl2)
  );

  // flags: reset low forces them without waiting for a clock
  assign room1 = FULL_LEVEL - lvl1;
  assign room2 = FULL_LEVEL - lvl2;
  assign port_a_full_or_input_ready   = ira; // RL1 RL17
  assign port_b_empty_or_output_ready = out_vld1 && !rst1_low; // RL1 RL17 RL19
  assign port_b_almost_empty_n        = !rst1_low && (OFS_W'(lvl1) > x1_q); // RL1
  assign port_a_almost_full_n         = rst1_low || (OFS_W'(room1) > y1_q); // RL1
  assign mailbox_one_flag_n           = mailbox_one_flag_n_q || rst1_low; // RL1
  assign port_b_full_or_input_ready   = irb; // RL2 RL17
  assign port_a_empty_or_output_ready = out_vld2 && !rst2_low; // RL2
  assign port_a_almost_empty_n        = !rst2_low && (OFS_W'(lvl2) > x2_q); // RL2
  assign port_b_almost_full_n         = rst2_low || (OFS_W'(room2) > y2_q); // RL2
  assign mailbox_two_flag_n           = mailbox_two_flag_n_q || rst2_low; // RL2
  assign offsets_ready                = prog_done_q;

  // output buses: mailbox select steers the mux directly
  assign port_b_data_out = port_b_mailbox_select ? mail1_q : fifo1_dout; // RL4 RL6
  assign port_a_data_out = port_a_mailbox_select ? mail2_q : fifo2_dout; // RL5 RL6
  assign port_b_data_oe  = !port_b_chip_select_n && port_b_write_read; // RL7
  assign port_a_data_oe  = !port_a_chip_select_n && !port_a_write_read; // RL18

  // mailbox flags: reset wins, then a new mail over a same-cycle read
  assign mailbox_one_flag_n_d = rst1_low ? 1'h1 : mail1_wr ? 1'h0 : mail1_rd ? 1'h1 : mailbox_one_flag_n_q; // RL3
  assign mailbox_two_flag_n_d = rst2_low ? 1'h1 : mail2_wr ? 1'h0 : mail2_rd ? 1'h1 : mailbox_two_flag_n_q; // RL3

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mail1_q <= '0;
      mail2_q <= '0;
      mailbox_one_flag_n_q  <= 1'b1;
      mailbox_two_flag_n_q  <= 1'b1;
    end else begin
      mailbox_one_flag_n_q <= mailbox_one_flag_n_d;
      mailbox_two_flag_n_q <= mailbox_two_flag_n_d;
      if (mail1_wr) begin
        mail1_q <= port_a_data_in; // RL4
      end
      if (mail2_wr) begin
        mail2_q <= port_b_data_in; // RL5
      end
    end
  end

  // offset loading
  assign preset_val = (flag_select == FS_PRESET_8)  ? PRESET_8 :
                      (flag_select == FS_PRESET_16) ? PRESET_16 : PRESET_64;
  assign ser_word   = {ser_sr_q[SER_BITS-2:0], serial_offset_data};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prog_q      <= PROG_IDLE;
      prog_done_q <= 1'b0;
      par_idx_q   <= IDX_Y1;
      ser_cnt_q   <= '0;
      ser_sr_q    <= '0;
    end else if (mst1_rel) begin
      par_idx_q <= IDX_Y1;
      ser_cnt_q <= '0;
      if (flag_select == FS_PROGRAM) begin
        prog_q      <= serial_program_select ? PROG_SER : PROG_PAR;
        prog_done_q <= 1'b0;
      end else begin
        prog_q      <= PROG_IDLE;
        prog_done_q <= 1'b1; // RL11
      end
    end else begin
      case (prog_q)
        PROG_PAR: begin
          if (prog_par_wr) begin
            par_idx_q <= par_idx_q + 2'h1;
            if (par_idx_q == IDX_X2) begin
              prog_q      <= PROG_IDLE;
              prog_done_q <= 1'b1;
            end
          end
        end
        PROG_SER: begin
          if (ser_shift) begin
            ser_sr_q  <= ser_word;
            ser_cnt_q <= ser_cnt_q + SER_ONE;
            if (ser_cnt_q == SER_LAST) begin
              prog_q      <= PROG_IDLE;
              prog_done_q <= 1'b1;
            end
          end
        end
        default: begin
          prog_q <= PROG_IDLE;
        end
      endcase
    end
  end

  // offset registers; last serial bit lands y1 in the top field
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      x1_q <= PRESET_8;
      y1_q <= PRESET_8;
      x2_q <= PRESET_8;
      y2_q <= PRESET_8;
    end else begin
      if (mst1_rel && flag_select != FS_PROGRAM) begin
        x1_q <= preset_val; // RL11
        y1_q <= preset_val;
      end else if (prog_par_wr && par_idx_q == IDX_Y1) begin
        y1_q <= port_a_data_in[OFS_W-1:0]; // RL14
      end else if (prog_par_wr && par_idx_q == IDX_X1) begin
        x1_q <= port_a_data_in[OFS_W-1:0];
      end else if (ser_shift && ser_cnt_q == SER_LAST) begin
        y1_q <= ser_word[4*OFS_W-1 -: OFS_W]; // RL15
        x1_q <= ser_word[3*OFS_W-1 -: OFS_W];
      end
      if (mst2_rel && flag_select != FS_PROGRAM) begin
        x2_q <= preset_val; // RL12
        y2_q <= preset_val;
      end else if (prog_par_wr && par_idx_q == IDX_Y2) begin
        y2_q <= port_a_data_in[OFS_W-1:0];
      end else if (prog_par_wr && par_idx_q == IDX_X2) begin
        x2_q <= port_a_data_in[OFS_W-1:0];
      end else if (ser_shift && ser_cnt_q == SER_LAST) begin
        y2_q <= ser_word[2*OFS_W-1 -: OFS_W];
        x2_q <= ser_word[OFS_W-1 -: OFS_W];
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_rst1_flags: assert property (rst1_low |-> !port_a_full_or_input_ready && !port_b_empty_or_output_ready // RL1
    && !port_b_almost_empty_n && port_a_almost_full_n && mailbox_one_flag_n)
    else $error("fifo one reset flags wrong");
  a_rst2_flags: assert property (rst2_low |-> !port_b_full_or_input_ready && !port_a_empty_or_output_ready // RL2
    && !port_a_almost_empty_n && port_b_almost_full_n && mailbox_two_flag_n)
    else $error("fifo two reset flags wrong");
  a_mail_flag_set: assert property (mail1_wr && !rst1_low ##1 !rst1_low |-> !mailbox_one_flag_n) // RL3
    else $error("mail one flag not low after write");
  a_mail_flag_clr: assert property (mail2_rd && !mail2_wr |=> mailbox_two_flag_n) // RL3
    else $error("mail two flag not high after read");
  a_mail_one_bypass: assert property (mail1_wr ##1 (port_b_mailbox_select && !mail1_wr) // RL4
    |-> port_b_data_out == $past(port_a_data_in))
    else $error("mail one data not on port b");
  a_mail_two_bypass: assert property (mail2_wr ##1 (port_a_mailbox_select && !mail2_wr) // RL5
    |-> port_a_data_out == $past(port_b_data_in))
    else $error("mail two data not on port a");
  a_mbsel_switch: assert property ($rose(port_b_mailbox_select) |-> port_b_data_out == mail1_q) // RL6
    else $error("port b bus did not switch to mail");
  a_port_b_drive: assert property (port_b_data_oe |-> !port_b_chip_select_n && port_b_write_read) // RL7
    else $error("port b driven out of read");
  a_port_a_drive: assert property (port_a_data_oe |-> !port_a_chip_select_n && !port_a_write_read) // RL18
    else $error("port a driven out of read");
  a_rst_four_edges: assert property ($rose(flush1) |-> rst1_low && $past(rst1_low, 1) && $past(rst1_low, 3)) // RL8
    else $error("fifo one reset taken early");
  a_preset_load: assert property (mst1_rel && flag_select != FS_PROGRAM |=> x1_q == $past(preset_val) // RL11
    && y1_q == $past(preset_val) && prog_done_q)
    else $error("preset offset not loaded");
  a_writes_ignored: assert property (!prog_done_q |-> !fifo1_push && !port_a_full_or_input_ready) // RL16
    else $error("port a write taken before ready");
  a_empty_update: assert property (fifo1_push && lvl1 == '0 && !flush1 ##1 !rst1_low // RL17
    |-> port_b_empty_or_output_ready)
    else $error("port b output ready late");

  c_mail_one: cover property (mail1_wr ##1 mail1_rd);
  c_fifo_pass: cover property (fifo1_push ##[1:4] fifo1_pop);
  c_serial_done: cover property (ser_shift && ser_cnt_q == SER_LAST);
  c_fifo_full: cover property (!in_rdy1 && !flush1);

endmodule

// [bfmc_host_b.sv]
// port b host model: level requests from the bench become port b pins
// assumes requests change at the falling edge of the shared clock
`timescale 1ns/100ps
module bfmc_host_b
  import bfmc_pkg::*;
(
  // requests
  input  wire logic              rd_req,
  input  wire logic              wr_req,
  input  wire logic              sel_mb,
  input  wire logic [DATA_W-1:0] wdata,
  // port b pins
  output logic                   cs_n,
  output logic                   write_read,
  output logic                   enable,
  output logic                   mb_sel,
  output logic [DATA_W-1:0]      data_to_dev,
  input  wire logic [DATA_W-1:0] data_from_dev,
  input  wire logic              dev_oe,
  // bus as seen on the wire
  output logic [DATA_W-1:0]      bus
);
  logic [DATA_W-1:0] last_q;
  assign cs_n        = !(rd_req || wr_req);
  assign write_read  = rd_req;
  assign enable      = rd_req || wr_req;
  assign mb_sel      = sel_mb;
  // released lines carry no stale copy of the write data
  assign data_to_dev = wr_req ? wdata : ~wdata;
  always @(data_from_dev or dev_oe) begin
    if (dev_oe) last_q = data_from_dev;
  end
  // floating bus shows the inverse of the last driven word
  assign bus = dev_oe ? data_from_dev : ~last_q;
endmodule

// [tb_top.sv]
// bench for the fifo reset, offset and mailbox control block
// assumes one 40 MHz clock; port b driven through the host model
`timescale 1ns/100ps
module tb_top;
  import bfmc_pkg::*;
  logic              clk, resetn;
  logic              fifo_one_master_reset_n, fifo_one_partial_reset_n;
  logic              fifo_two_master_reset_n, fifo_two_partial_reset_n;
  logic [1:0]        flag_select;
  logic              serial_program_select, serial_offset_data, serial_enable_n;
  logic              port_a_chip_select_n, port_a_write_read, port_a_enable, port_a_mailbox_select;
  logic              port_b_chip_select_n, port_b_write_read, port_b_enable, port_b_mailbox_select;
  logic [DATA_W-1:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out, b_wdata, b_bus;
  logic              port_a_data_oe, port_b_data_oe, offsets_ready, b_rd, b_wr, b_mb;
  logic              port_a_full_or_input_ready, port_b_full_or_input_ready;
  logic              port_a_empty_or_output_ready, port_b_empty_or_output_ready;
  logic              port_a_almost_empty_n, port_b_almost_empty_n, port_a_almost_full_n, port_b_almost_full_n;
  logic              mailbox_one_flag_n, mailbox_two_flag_n;
  int                miscompares = 0;
  int                compares = 0;
  wire  [4:0]        f1 = {port_b_almost_empty_n, port_a_almost_full_n, port_a_full_or_input_ready,
                           port_b_empty_or_output_ready, mailbox_one_flag_n};
  wire  [4:0]        f2 = {port_a_almost_empty_n, port_b_almost_full_n, port_b_full_or_input_ready,
                           port_a_empty_or_output_ready, mailbox_two_flag_n};

  bfmc_ctl bfmc_ctl_inst (.*);
  bfmc_host_b bfmc_host_b_inst (.rd_req(b_rd), .wr_req(b_wr), .sel_mb(b_mb), .wdata(b_wdata),
    .cs_n(port_b_chip_select_n), .write_read(port_b_write_read), .enable(port_b_enable),
    .mb_sel(port_b_mailbox_select), .data_to_dev(port_b_data_in), .data_from_dev(port_b_data_out),
    .dev_oe(port_b_data_oe), .bus(b_bus));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic a_set(input logic on, input logic wr, input logic mb, input logic [DATA_W-1:0] d);
    port_a_chip_select_n = !on;
    port_a_write_read = wr;
    port_a_enable = on;
    port_a_mailbox_select = mb;
    port_a_data_in = d;
  endtask

  // other pins of both fifos stay high while one is held in reset
  task automatic fifo_reset(input int which, input int edges, input logic [1:0] fs);
    flag_select = fs;
    fifo_one_master_reset_n = (which != 0);
    fifo_one_partial_reset_n = (which != 1);
    fifo_two_master_reset_n = (which != 2);
    fifo_two_partial_reset_n = (which != 3);
    #1;
    if (which < 2) chk("fifo one forced", 5'h09, f1);
    if (which > 1) chk("fifo two forced", 5'h09, f2);
    repeat (edges) @(negedge clk);
    {fifo_one_master_reset_n, fifo_one_partial_reset_n} = 2'h3;
    {fifo_two_master_reset_n, fifo_two_partial_reset_n} = 2'h3;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_before;
    a_set(1, 1, 0, 36'h000000011);
    @(negedge clk);
    a_set(0, 0, 0, 36'h0);
    @(negedge clk);
    chk("a in ready", 0, port_a_full_or_input_ready);
    chk("b out ready", 0, port_b_empty_or_output_ready);
    $display("test before_offsets done");
  endtask

  task automatic t_master;
    fifo_reset(0, 4, FS_PRESET_8);
    chk("offsets ready", 1, offsets_ready);
    chk("a in ready", 1, port_a_full_or_input_ready);
    fifo_reset(2, 4, FS_PRESET_8);
    chk("b in ready", 1, port_b_full_or_input_ready);
    $display("test master_reset done");
  endtask

  task automatic t_fill_drain;
    for (int i = 1; i <= 17; i++) begin
      a_set(1, 1, 0, 36'hC00000000 + 36'(i));
      @(negedge clk);
      if (i <= 16) chk("b almost empty", 36'(i > 8), port_b_almost_empty_n);
      if (i <= 16) chk("a almost full", 36'(i < 8), port_a_almost_full_n);
    end
    a_set(0, 0, 0, 36'h0);
    chk("a in ready full", 0, port_a_full_or_input_ready);
    for (int i = 1; i <= 16; i++) begin
      b_rd = 1;
      @(negedge clk);
      chk("b bus word", 36'hC00000000 + 36'(i), b_bus);
      if (i == 8) begin
        b_rd = 0;
        repeat (2) @(negedge clk);
      end
    end
    chk("b out ready", 0, port_b_empty_or_output_ready);
    b_rd = 0;
    $display("test fill_drain done");
  endtask

  task automatic t_mailbox;
    a_set(1, 1, 1, 36'h9A5A5A5A5);
    @(negedge clk);
    a_set(0, 0, 0, 36'h0);
    chk("mail one flag", 0, mailbox_one_flag_n);
    b_rd = 1;
    b_mb = 1;
    #1 chk("b bus mail", 36'h9A5A5A5A5, b_bus);
    b_mb = 0;
    #1 chk("b bus fifo", 36'hC00000010, b_bus);
    b_mb = 1;
    @(negedge clk);
    b_rd = 0;
    chk("mail one flag", 1, mailbox_one_flag_n);
    b_wr = 1;
    b_wdata = 36'h35C3C3C3C;
    @(negedge clk);
    chk("b oe write", 0, port_b_data_oe);
    b_wr = 0;
    b_mb = 0;
    chk("mail two flag", 0, mailbox_two_flag_n);
    a_set(1, 0, 1, 36'h0);
    #1 chk("a mail", 36'h35C3C3C3C, port_a_data_out);
    @(negedge clk);
    a_set(0, 0, 0, 36'h0);
    chk("mail two flag", 1, mailbox_two_flag_n);
    $display("test mailbox done");
  endtask

  task automatic t_partial;
    a_set(1, 1, 0, 36'h000000077);
    @(negedge clk);
    a_set(0, 0, 0, 36'h0);
    fifo_reset(1, 3, FS_PROGRAM);
    chk("b out ready kept", 1, port_b_empty_or_output_ready);
    fifo_reset(1, 4, FS_PROGRAM);
    chk("b out ready flushed", 0, port_b_empty_or_output_ready);
    chk("offsets kept", 1, offsets_ready);
    fifo_reset(3, 4, FS_PROGRAM);
    chk("b in ready", 1, port_b_full_or_input_ready);
    $display("test partial_reset done");
  endtask

  task automatic t_oe;
    for (int i = 0; i < 4; i++) begin
      port_a_chip_select_n = i[0];
      port_a_write_read = i[1];
      #1 chk("a oe", 36'(!i[0] && !i[1]), port_a_data_oe);
    end
    chk("b oe idle", 0, port_b_data_oe);
    a_set(0, 0, 0, 36'h0);
    @(negedge clk);
    $display("test bus_enable done");
  endtask

  task automatic t_parallel;
    serial_program_select = 0;
    fifo_reset(0, 4, FS_PROGRAM);
    chk("offsets ready", 0, offsets_ready);
    for (int i = 0; i < 4; i++) begin
      a_set(1, 1, 0, 36'(i + 2));
      @(negedge clk);
      a_set(0, 0, 0, 36'h0);
      @(negedge clk);
    end
    chk("offsets ready", 1, offsets_ready);
    chk("b out ready", 0, port_b_empty_or_output_ready);
    for (int i = 1; i <= 4; i++) begin
      a_set(1, 1, 0, 36'(i));
      @(negedge clk);
      chk("b almost empty", 36'(i > 3), port_b_almost_empty_n);
    end
    a_set(0, 0, 0, 36'h0);
    $display("test parallel_offsets done");
  endtask

  task automatic t_serial;
    logic [SER_BITS-1:0] w = 28'h1E00184;
    serial_program_select = 1;
    fifo_reset(0, 4, FS_PROGRAM);
    for (int i = SER_BITS - 1; i >= 0; i--) begin
      {serial_enable_n, serial_offset_data} = {1'h0, w[i]};
      @(negedge clk);
      if (i == 14) begin
        serial_enable_n = 1;
        @(negedge clk);
      end
    end
    chk("offsets ready", 1, offsets_ready);
    a_set(1, 1, 0, 36'h1);
    @(negedge clk);
    a_set(0, 0, 0, 36'h0);
    chk("b almost empty", 1, port_b_almost_empty_n);
    $display("test serial_offsets done");
  endtask

  initial begin
    resetn = 0;
    {fifo_one_master_reset_n, fifo_one_partial_reset_n} = 2'h3;
    {fifo_two_master_reset_n, fifo_two_partial_reset_n} = 2'h3;
    flag_select = FS_PRESET_8;
    {serial_program_select, serial_offset_data, serial_enable_n} = 3'h1;
    a_set(0, 0, 0, 36'h0);
    {b_rd, b_wr, b_mb} = 3'h0;
    b_wdata = 36'h0;
    repeat (5) @(negedge clk);
    resetn = 1;
    @(negedge clk);
    t_before;
    t_master;
    t_fill_drain;
    t_mailbox;
    t_partial;
    t_oe;
    t_parallel;
    t_serial;
    wrap_up;
  end

  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
endmodule
